// ===== core/sdbg_pkg.sv
package sdbg_pkg;

   // Serial engine states.
   typedef enum logic [2:0] {
      ST_CAL,
      ST_IDLE,
      ST_RX,
      ST_TX,
      ST_BRK_TX,
      ST_HOLD
   } sdbg_state_t;

   // Character framing: start, eight data bits, stop.
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] STOP_BIT_IDX = 4'h9;

   // Auto-baud limits in system clock cycles per bit.
   localparam logic [12:0] MIN_PERIOD = 13'h0004;
   localparam logic [12:0] MAX_PERIOD = 13'h0200;
   localparam logic [12:0] CAL_LOW_BITS = 13'h0008;
   localparam logic [12:0] MIN_CAL_CNT = MIN_PERIOD * CAL_LOW_BITS;
   localparam logic [12:0] MAX_CAL_CNT = MAX_PERIOD * CAL_LOW_BITS;
   // Nine bit times at the slowest rate ends any calibration attempt as a break.
   localparam logic [12:0] CAL_BREAK_CNT = MAX_PERIOD * 13'h0009;

   // Error answer: a break four characters of ten bit times long.
   localparam logic [15:0] BRK_TX_BITS = 16'h0028;

   // Debug control register layout and reset value.
   localparam int DBG_MODE_BIT = 7;
   localparam int BRK_EN_BIT = 6;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // Breakpoint opcode, pin unlock key and runtime counter ceiling.
   localparam logic [7:0] BRK_OPCODE = 8'h00;
   localparam logic [31:0] UNLOCK_KEY = 32'hEB5A70CD;
   localparam logic [15:0] RUNTIME_MAX = 16'hFFFF;

endpackage

// ===== core/sdbg_autobaud.sv
// Measures the low run of the calibration character and yields cycles per bit.
module sdbg_autobaud (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_line,
   output logic o_locked,
   output logic [9:0] o_period,
   output logic o_too_long
);

   logic armed_q;
   logic meas_q;
   logic [12:0] cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // Arm on a high level, count the low run, lock on the rising edge.
   // A run that is too short or too long leaves the detector unlocked.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || i_clear) begin
         armed_q <= 1'b0;
         meas_q <= 1'b0;
         cnt_q <= 13'h0000;
         o_locked <= 1'b0;
         o_period <= 10'h000;
         o_too_long <= 1'b0;
      end else begin
         o_too_long <= 1'b0;
         if (!o_locked) begin
            if (!meas_q) begin
               if (i_line) begin
                  armed_q <= 1'b1;
               end else if (armed_q) begin
                  meas_q <= 1'b1;
                  cnt_q <= 13'h0001;
               end
            end else if (!i_line) begin
               if (cnt_q == sdbg_pkg::CAL_BREAK_CNT) begin
                  o_too_long <= 1'b1;
                  meas_q <= 1'b0;
                  armed_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 13'h0001;
               end
            end else begin
               meas_q <= 1'b0;
               if (cnt_q >= sdbg_pkg::MIN_CAL_CNT && cnt_q <= sdbg_pkg::MAX_CAL_CNT) begin
                  o_locked <= 1'b1;
                  o_period <= cnt_q[12:3];
               end
            end
         end
      end
   end

endmodule

// ===== core/sdbg_port.sv
module sdbg_port (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_sys_rst_n,
   input wire logic i_small_pkg,
   input wire logic i_dbg_in,
   output logic o_dbg_out,
   output logic o_dbg_oe,
   output logic o_gpio_mode,
   output logic o_baud_locked,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic o_abort,
   output logic o_err_break,
   output logic o_err_frame,
   output logic o_err_coll,
   input wire logic i_ctl_wr,
   input wire logic [7:0] i_ctl_data,
   output logic [7:0] o_ctl_reg,
   input wire logic i_decode_valid,
   input wire logic [7:0] i_opcode,
   output logic o_brk_nop,
   input wire logic i_exec_req,
   input wire logic i_halt_mode,
   input wire logic i_stop_mode,
   output logic o_fetch_stop,
   output logic o_exit_halt,
   output logic o_wdt_refresh,
   output logic o_sys_reset_req,
   output logic [15:0] o_runtime
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   sdbg_pkg::sdbg_state_t state_q;
   logic [15:0] tmr_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [13:0] low_cnt_q;
   logic unlocked_q;
   logic [31:0] key_q;
   logic in_rst_q;
   logic strap_q;
   logic mode_d1_q;
   logic ab_locked;
   logic [9:0] ab_period;
   logic ab_too_long;
   logic ser_active;
   logic ab_clear;
   logic [15:0] p16;
   logic [15:0] half16;
   logic [13:0] nine_bits;
   logic [15:0] brk_len;
   logic brk_det;
   logic frm_det;
   logic coll_det;
   logic err_det;
   logic strap_entry;
   logic brk_hit;

   // Breakpoint decode is shared by the entry and the nop paths.
   function automatic logic is_brk(input logic valid, input logic [7:0] op);
      is_brk = valid && (op == sdbg_pkg::BRK_OPCODE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Auto-baud detector and derived bit timing.

   assign ser_active = !i_small_pkg || unlocked_q || !i_sys_rst_n;
   assign ab_clear = (state_q == sdbg_pkg::ST_HOLD) || !ser_active;

   sdbg_autobaud u_autobaud (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clear(ab_clear),
      .i_line(i_dbg_in),
      .o_locked(ab_locked),
      .o_period(ab_period),
      .o_too_long(ab_too_long)
   );

   assign o_baud_locked = ab_locked;
   assign p16 = {6'h00, ab_period};
   assign half16 = {7'h00, ab_period[9:1]};
   assign nine_bits = ({4'h0, ab_period} << 3) + {4'h0, ab_period};
   assign brk_len = 16'((32'(p16) * 32'(sdbg_pkg::BRK_TX_BITS)));

   // The pin only ever pulls low; the external pull-up provides the high.
   // open-drain drive
   assign o_dbg_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Error detection.

   assign brk_det = ((state_q == sdbg_pkg::ST_IDLE) || (state_q == sdbg_pkg::ST_RX))
                    && (low_cnt_q >= nine_bits);
   assign frm_det = (state_q == sdbg_pkg::ST_RX) && (tmr_q == 16'h0000)
                    && (bit_q == sdbg_pkg::STOP_BIT_IDX) && !i_dbg_in;
   assign coll_det = (state_q == sdbg_pkg::ST_TX) && (tmr_q == half16)
                     && !o_dbg_oe && !i_dbg_in;
   assign err_det = brk_det || frm_det || coll_det;

   // Low run length seen from outside; our own drive does not count.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || !ser_active) begin
         low_cnt_q <= 14'h0000;
      end else if (i_dbg_in || o_dbg_oe) begin
         low_cnt_q <= 14'h0000;
      end else if (low_cnt_q != 14'h3FFF) begin
         low_cnt_q <= low_cnt_q + 14'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial engine: calibration, receive, transmit and error break.
   // Receive and transmit share one state register, which keeps them exclusive.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || !ser_active) begin
         state_q <= sdbg_pkg::ST_CAL;
         tmr_q <= 16'h0000;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         o_dbg_oe <= 1'b0;
         o_rx_data <= 8'h00;
         o_rx_valid <= 1'b0;
         o_tx_ready <= 1'b0;
         o_abort <= 1'b0;
         o_err_break <= 1'b0;
         o_err_frame <= 1'b0;
         o_err_coll <= 1'b0;
      end else begin
         o_rx_valid <= 1'b0;
         o_abort <= 1'b0;
         o_err_break <= 1'b0;
         o_err_frame <= 1'b0;
         o_err_coll <= 1'b0;
         if (err_det) begin
            state_q <= sdbg_pkg::ST_BRK_TX;
            tmr_q <= brk_len - 16'h0001;
            o_dbg_oe <= 1'b1;
            o_tx_ready <= 1'b0;
            o_abort <= 1'b1;
            o_err_break <= brk_det;
            o_err_frame <= frm_det;
            o_err_coll <= coll_det;
         end else begin
            case (state_q)
               sdbg_pkg::ST_CAL: begin
                  o_dbg_oe <= 1'b0;
                  o_tx_ready <= 1'b0;
                  o_err_break <= ab_too_long;
                  if (ab_locked) begin
                     state_q <= sdbg_pkg::ST_IDLE;
                     o_tx_ready <= 1'b1;
                  end
               end
               sdbg_pkg::ST_IDLE: begin
                  o_dbg_oe <= 1'b0;
                  if (i_tx_valid && o_tx_ready) begin
                     state_q <= sdbg_pkg::ST_TX;
                     sh_q <= i_tx_data;
                     bit_q <= 4'h0;
                     tmr_q <= p16 - 16'h0001;
                     o_dbg_oe <= 1'b1;
                     o_tx_ready <= 1'b0;
                  end else if (!i_dbg_in) begin
                     state_q <= sdbg_pkg::ST_RX;
                     bit_q <= 4'h0;
                     tmr_q <= half16 - 16'h0001;
                     o_tx_ready <= 1'b0;
                  end
               end
               sdbg_pkg::ST_RX: begin
                  if (tmr_q != 16'h0000) begin
                     tmr_q <= tmr_q - 16'h0001;
                  end else begin
                     tmr_q <= p16 - 16'h0001;
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h0) begin
                        if (i_dbg_in) begin
                           state_q <= sdbg_pkg::ST_IDLE;
                           o_tx_ready <= 1'b1;
                        end
                     end else if (bit_q <= sdbg_pkg::DATA_BITS) begin
                        sh_q <= {i_dbg_in, sh_q[7:1]};
                     end else begin
                        o_rx_data <= sh_q;
                        o_rx_valid <= 1'b1;
                        state_q <= sdbg_pkg::ST_IDLE;
                        o_tx_ready <= 1'b1;
                     end
                  end
               end
               sdbg_pkg::ST_TX: begin
                  if (tmr_q != 16'h0000) begin
                     tmr_q <= tmr_q - 16'h0001;
                  end else begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q < sdbg_pkg::DATA_BITS) begin
                        o_dbg_oe <= !sh_q[0];
                        sh_q <= {1'b0, sh_q[7:1]};
                        tmr_q <= p16 - 16'h0001;
                     end else if (bit_q == sdbg_pkg::DATA_BITS) begin
                        o_dbg_oe <= 1'b0;
                        tmr_q <= p16 + half16 - 16'h0001;
                     end else begin
                        state_q <= sdbg_pkg::ST_IDLE;
                        o_tx_ready <= 1'b1;
                     end
                  end
               end
               sdbg_pkg::ST_BRK_TX: begin
                  // Driving low only stretches a host break; it never shortens it.
                  if (tmr_q != 16'h0000) begin
                     tmr_q <= tmr_q - 16'h0001;
                  end else begin
                     o_dbg_oe <= 1'b0;
                     state_q <= sdbg_pkg::ST_HOLD;
                  end
               end
               sdbg_pkg::ST_HOLD: begin
                  o_dbg_oe <= 1'b0;
                  if (i_dbg_in) begin
                     state_q <= sdbg_pkg::ST_CAL;
                  end
               end
               default: begin
                  state_q <= sdbg_pkg::ST_CAL;
                  o_dbg_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Small package unlock: key bytes are only honoured while system reset is on.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         unlocked_q <= 1'b0;
         key_q <= 32'h0000_0000;
         o_gpio_mode <= 1'b1;
      end else begin
         o_gpio_mode <= i_small_pkg && !unlocked_q;
         if (!i_sys_rst_n && o_rx_valid) begin
            key_q <= {key_q[23:0], o_rx_data};
            if ({key_q[23:0], o_rx_data} == sdbg_pkg::UNLOCK_KEY) begin
               unlocked_q <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin level strap across system reset; captured on the clock, not by reset.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         in_rst_q <= 1'b0;
         strap_q <= 1'b1;
      end else begin
         in_rst_q <= !i_sys_rst_n;
         if (!i_sys_rst_n) begin
            strap_q <= i_dbg_in;
         end
      end
   end

   assign strap_entry = in_rst_q && i_sys_rst_n && !strap_q && !i_small_pkg;
   assign brk_hit = is_brk(i_decode_valid, i_opcode) && o_ctl_reg[sdbg_pkg::BRK_EN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Debug control register. Serial breaks never touch it; a system reset does.
   // Hardware entry beats a same-cycle software write that clears the mode bit.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || !i_sys_rst_n) begin
         o_ctl_reg <= sdbg_pkg::CTL_RESET;
      end else begin
         if (i_ctl_wr) begin
            o_ctl_reg <= i_ctl_data;
         end
         if (strap_entry || brk_hit) begin
            o_ctl_reg[sdbg_pkg::DBG_MODE_BIT] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Processor side controls, all registered.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_fetch_stop <= 1'b0;
         o_exit_halt <= 1'b0;
         o_wdt_refresh <= 1'b0;
         o_brk_nop <= 1'b0;
         o_sys_reset_req <= 1'b0;
      end else begin
         o_fetch_stop <= o_ctl_reg[sdbg_pkg::DBG_MODE_BIT] && !i_exec_req;
         o_exit_halt <= o_ctl_reg[sdbg_pkg::DBG_MODE_BIT] && i_halt_mode;
         o_wdt_refresh <= o_ctl_reg[sdbg_pkg::DBG_MODE_BIT];
         o_brk_nop <= is_brk(i_decode_valid, i_opcode)
                      && !o_ctl_reg[sdbg_pkg::BRK_EN_BIT];
         o_sys_reset_req <= i_stop_mode && !i_dbg_in && (!i_small_pkg || unlocked_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Runtime counter: cleared when debug mode is left, then counts until
   // debug mode returns or the ceiling is hit. It is not cleared by entry so
   // the debugger can read the run length afterwards.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         mode_d1_q <= 1'b0;
         o_runtime <= 16'h0000;
      end else begin
         mode_d1_q <= o_ctl_reg[sdbg_pkg::DBG_MODE_BIT];
         if (mode_d1_q && !o_ctl_reg[sdbg_pkg::DBG_MODE_BIT]) begin
            o_runtime <= 16'h0000;
         end else if (!o_ctl_reg[sdbg_pkg::DBG_MODE_BIT]
                      && (o_runtime != sdbg_pkg::RUNTIME_MAX)) begin
            o_runtime <= o_runtime + 16'h0001;
         end
      end
   end

endmodule

// ===== tb/sdbg_host.sv
module sdbg_host #(
   parameter int P = 8
) (
   input wire logic i_clock,
   input wire logic i_pin,
   output logic o_pull
);
   timeunit 1ns;
   timeprecision 1ns;

   // The host starts released, so the pull-up holds the line high.
   initial o_pull = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // host line break
   task automatic hold_low(input int n);
      @(negedge i_clock);
      o_pull = 1'b1;
      repeat (n) @(negedge i_clock);
      o_pull = 1'b0;
   endtask

   task automatic send(input logic [7:0] b, input logic stop_ok);
      @(negedge i_clock);
      o_pull = 1'b1;
      repeat (P) @(negedge i_clock);
      for (int i = 0; i < 8; i++) begin
         o_pull = ~b[i];
         repeat (P) @(negedge i_clock);
      end
      o_pull = ~stop_ok;
      repeat (P + P / 2) @(negedge i_clock);
      o_pull = 1'b0;
   endtask

   task automatic calib();
      send(8'h80, 1'b1);
   endtask

   task automatic recv(output logic [7:0] b, output logic stop, output logic ok);
      int n;
      n = 0;
      while (i_pin !== 1'b0 && n < 2000) begin
         @(negedge i_clock);
         n++;
      end
      ok = (n < 2000);
      repeat (P / 2) @(negedge i_clock);
      for (int i = 0; i < 8; i++) begin
         repeat (P) @(negedge i_clock);
         b[i] = i_pin;
      end
      repeat (P) @(negedge i_clock);
      stop = i_pin;
   endtask
endmodule

// ===== tb/sdbg_port_asserts.sv
module sdbg_port_asserts (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_sys_rst_n,
   input wire logic i_small_pkg,
   input wire logic i_dbg_in,
   input wire logic o_dbg_out,
   input wire logic o_dbg_oe,
   input wire logic o_rx_valid,
   input wire logic i_tx_valid,
   input wire logic o_tx_ready,
   input wire logic o_abort,
   input wire logic o_err_frame,
   input wire logic o_err_coll,
   input wire logic [7:0] o_ctl_reg,
   input wire logic i_decode_valid,
   input wire logic [7:0] i_opcode,
   input wire logic o_brk_nop,
   input wire logic i_exec_req,
   input wire logic i_halt_mode,
   input wire logic i_stop_mode,
   input wire logic o_fetch_stop,
   input wire logic o_exit_halt,
   input wire logic o_wdt_refresh,
   input wire logic o_sys_reset_req,
   input wire logic [15:0] o_runtime
);
   // Everything here belongs to the one system clock domain.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   a_open_drain: assert property (
      o_dbg_out == 1'b0 && !(o_rx_valid && o_dbg_oe))
      else $error("pin driven high or sending while receiving");
   a_tx_start: assert property (
      i_tx_valid && o_tx_ready |=> o_dbg_oe && !o_tx_ready)
      else $error("no start bit after a taken byte");
   a_err_abort: assert property (
      o_err_frame || o_err_coll |-> o_abort)
      else $error("serial error without abort");
   a_err_answer: assert property (
      $rose(o_abort) |-> ##[0:1] o_dbg_oe [*8])
      else $error("no break sent back after abort");
   a_brk_enter: assert property (
      i_decode_valid && i_opcode == 8'h00 && o_ctl_reg[6] && i_sys_rst_n |=> o_ctl_reg[7])
      else $error("enabled breakpoint did not enter debug mode");
   a_brk_nop: assert property (
      i_decode_valid && i_opcode == 8'h00 && !o_ctl_reg[6] |=> o_brk_nop)
      else $error("disabled breakpoint not run as nop");
   a_nop_cause: assert property (
      o_brk_nop |-> $past(i_decode_valid) && $past(i_opcode) == 8'h00)
      else $error("nop pulse without a breakpoint decode");
   a_sys_clear: assert property (
      !i_sys_rst_n |=> o_ctl_reg == 8'h00)
      else $error("system reset kept the control register");
   a_pin_strap: assert property (
      !i_sys_rst_n && !i_dbg_in && !i_small_pkg ##1 i_sys_rst_n |-> ##[1:2] o_ctl_reg[7])
      else $error("low pin at reset end did not enter debug mode");
   a_debug_state: assert property (
      o_ctl_reg[7] && !i_exec_req |=> o_fetch_stop && o_wdt_refresh)
      else $error("debug mode without fetch stop or watchdog refresh");
   a_halt_exit: assert property (
      o_ctl_reg[7] && i_halt_mode |=> o_exit_halt)
      else $error("halt not left in debug mode");
   a_stop_reset: assert property (
      i_stop_mode && !i_dbg_in && !i_small_pkg |=> o_sys_reset_req)
      else $error("low pin in stop state gave no system reset");
   a_run_hold: assert property (
      o_ctl_reg[7] [*2] |=> $stable(o_runtime))
      else $error("runtime counter moved in debug mode");
   a_run_count: assert property (
      (!o_ctl_reg[7] && i_sys_rst_n) [*5] ##0 o_runtime != 16'hFFFF
      |=> o_runtime == $past(o_runtime) + 16'h0001)
      else $error("runtime counter did not count");

   // The main scenarios: a byte received, an error answered, debug mode entered with fetch stopped.
   c_rx: cover property (o_rx_valid);
   c_abort: cover property (o_abort);
   c_debug: cover property (o_ctl_reg[7] && o_fetch_stop);
endmodule

bind sdbg_port sdbg_port_asserts u_chk (
   .i_clock, .i_rst_n, .i_sys_rst_n, .i_small_pkg, .i_dbg_in, .o_dbg_out, .o_dbg_oe,
   .o_rx_valid, .i_tx_valid, .o_tx_ready, .o_abort, .o_err_frame, .o_err_coll,
   .o_ctl_reg, .i_decode_valid, .i_opcode, .o_brk_nop, .i_exec_req, .i_halt_mode,
   .i_stop_mode, .o_fetch_stop, .o_exit_halt, .o_wdt_refresh, .o_sys_reset_req, .o_runtime
);

// ===== tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   // Eight clocks per bit, the recommended fastest rate.
   localparam int P = 8;

   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_sys_rst_n = 1'b1;
   logic i_small_pkg = 1'b0;
   logic i_tx_valid = 1'b0;
   logic i_ctl_wr = 1'b0;
   logic i_decode_valid = 1'b0;
   logic i_exec_req = 1'b0;
   logic i_halt_mode = 1'b0;
   logic i_stop_mode = 1'b0;
   logic [7:0] i_tx_data = 8'h00;
   logic [7:0] i_ctl_data = 8'h00;
   logic [7:0] i_opcode = 8'h00;
   logic pin, host_pull, o_dbg_out, o_dbg_oe, o_gpio_mode, o_baud_locked, o_rx_valid;
   logic o_tx_ready, o_abort, o_err_break, o_err_frame, o_err_coll, o_brk_nop;
   logic o_fetch_stop, o_exit_halt, o_wdt_refresh, o_sys_reset_req;
   logic [7:0] o_rx_data, o_ctl_reg;
   logic [15:0] o_runtime;
   int errors = 0;
   int comparisons = 0;

   // Open-drain wire with a pull-up: low whenever either party pulls.
   assign pin = ~((o_dbg_oe & ~o_dbg_out) | host_pull);

   // Clock of 50 ns period.
   always #25 i_clock = ~i_clock;

   sdbg_port u_dut (
      .i_clock, .i_rst_n, .i_sys_rst_n, .i_small_pkg, .i_dbg_in(pin), .o_dbg_out,
      .o_dbg_oe, .o_gpio_mode, .o_baud_locked, .o_rx_data, .o_rx_valid, .i_tx_data,
      .i_tx_valid, .o_tx_ready, .o_abort, .o_err_break, .o_err_frame, .o_err_coll,
      .i_ctl_wr, .i_ctl_data, .o_ctl_reg, .i_decode_valid, .i_opcode, .o_brk_nop,
      .i_exec_req, .i_halt_mode, .i_stop_mode, .o_fetch_stop, .o_exit_halt,
      .o_wdt_refresh, .o_sys_reset_req, .o_runtime
   );
   sdbg_host #(.P(P)) u_host (.i_clock, .i_pin(pin), .o_pull(host_pull));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask

   function automatic logic sel(input int w);
      case (w)
         0: return o_rx_valid;
         1: return o_err_break;
         2: return o_err_frame;
         3: return o_err_coll;
         4: return o_baud_locked;
         5: return pin;
         default: return o_tx_ready;
      endcase
   endfunction

   task automatic wait_ev(input int w, input int lim);
      int n;
      n = 0;
      while (sel(w) !== 1'b1) begin
         @(negedge i_clock);
         n++;
         if (n > lim) begin
            errors++;
            $display("FAIL %0t timeout waiting for event %0d", $time, w);
            test_done();
         end
      end
   endtask

   // One-cycle strobe of a control write (w = 0) or of an opcode decode.
   task automatic pulse(input int w, input logic [7:0] d, output logic nop);
      @(negedge i_clock);
      i_ctl_data = d;
      i_opcode = d;
      i_ctl_wr = (w == 0);
      i_decode_valid = (w != 0);
      @(negedge i_clock);
      nop = o_brk_nop;
      i_ctl_wr = 1'b0;
      i_decode_valid = 1'b0;
      @(negedge i_clock);
   endtask

   task automatic tx_put(input logic [7:0] d);
      wait_ev(6, 400);
      i_tx_data = d;
      i_tx_valid = 1'b1;
      @(negedge i_clock);
      i_tx_valid = 1'b0;
   endtask

   task automatic cal();
      wait_ev(5, 2000);
      repeat (4) @(negedge i_clock);
      chk(o_baud_locked === 1'b0, "calibration expected");
      u_host.calib();
      wait_ev(4, 4 * P);
      chk(o_tx_ready === 1'b1, "port calibrated");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_rx();
      fork
         begin
            u_host.send(8'hA5, 1'b1);
            u_host.send(8'h3C, 1'b1);
         end
         begin
            wait_ev(0, 12 * P);
            chk(o_rx_data === 8'hA5, "first byte received");
            @(negedge i_clock);
            wait_ev(0, 12 * P);
            chk(o_rx_data === 8'h3C, "second byte received");
         end
      join
      $display("Test rx finished");
   endtask

   task automatic t_tx();
      logic [7:0] b;
      logic s, ok;
      fork
         begin
            tx_put(8'hC3);
            tx_put(8'h5A);
         end
         begin
            u_host.recv(b, s, ok);
            chk(ok && b === 8'hC3 && s === 1'b1, "first byte sent");
            u_host.recv(b, s, ok);
            chk(ok && b === 8'h5A && s === 1'b1, "second byte sent");
         end
      join
      $display("Test tx finished");
   endtask

   task automatic t_brk();
      logic nop;
      pulse(0, 8'h40, nop);
      pulse(1, 8'h00, nop);
      chk(o_ctl_reg === 8'hC0, "breakpoint enters debug mode");
      chk(o_fetch_stop === 1'b1 && o_wdt_refresh === 1'b1, "fetch stopped");
      fork
         u_host.hold_low(12 * P);
         wait_ev(1, 12 * P);
      join
      chk(o_ctl_reg === 8'hC0, "break keeps control and mode");
      cal();
      $display("Test break finished");
   endtask

   // The answer break must stay low for four characters of ten bits.
   task automatic t_frame();
      int n;
      fork
         u_host.send(8'h55, 1'b0);
         begin
            wait_ev(2, 12 * P);
            chk(o_abort === 1'b1, "abort on framing error");
            n = 0;
            @(negedge i_clock);
            while (o_dbg_oe === 1'b1 && n < 500) begin
               @(negedge i_clock);
               n++;
            end
            chk(n >= 40 * P - 2 && n <= 40 * P + 1, "answer break length");
         end
      join
      cal();
      $display("Test framing finished");
   endtask

   task automatic t_coll();
      fork
         tx_put(8'hFF);
         u_host.hold_low(10 * P);
         wait_ev(3, 3 * P);
      join
      cal();
      $display("Test collision finished");
   endtask

   task automatic t_run();
      logic [15:0] r;
      logic nop;
      pulse(0, 8'h00, nop);
      chk(o_ctl_reg[7] === 1'b0 && o_fetch_stop === 1'b0, "mode bit cleared");
      pulse(1, 8'h00, nop);
      chk(nop === 1'b1 && o_ctl_reg[7] === 1'b0, "disabled breakpoint");
      r = o_runtime;
      repeat (100) @(negedge i_clock);
      chk(o_runtime === r + 16'h0064, "runtime counts");
      pulse(0, 8'h80, nop);
      repeat (2) @(negedge i_clock);
      r = o_runtime;
      repeat (50) @(negedge i_clock);
      chk(o_runtime === r && o_ctl_reg[7] === 1'b1, "runtime held");
      i_halt_mode = 1'b1;
      i_stop_mode = 1'b1;
      u_host.hold_low(2);
      chk(o_exit_halt === 1'b1 && o_sys_reset_req === 1'b1, "halt, stop");
      i_halt_mode = 1'b0;
      i_stop_mode = 1'b0;
      $display("Test runtime finished");
   endtask

   // The pin is still low on the last cycle of system reset.
   task automatic t_sys();
      logic nop;
      logic [7:0] k [5] = '{8'h80, 8'hEB, 8'h5A, 8'h70, 8'hCD};
      @(negedge i_clock);
      i_sys_rst_n = 1'b0;
      fork
         u_host.hold_low(6);
         begin
            repeat (4) @(negedge i_clock);
            chk(o_ctl_reg === 8'h00, "system reset ends debug mode");
            i_sys_rst_n = 1'b1;
         end
      join
      chk(o_ctl_reg[7] === 1'b1, "pin strap enters debug mode");
      repeat (80) @(negedge i_clock);
      i_small_pkg = 1'b1;
      i_sys_rst_n = 1'b0;
      foreach (k[i]) begin
         u_host.send(k[i], 1'b1);
      end
      i_sys_rst_n = 1'b1;
      @(negedge i_clock);
      chk(o_gpio_mode === 1'b0, "shared pin unlocked");
      pulse(0, 8'h80, nop);
      chk(o_ctl_reg[7] === 1'b1, "debug mode after unlock");
      $display("Test system reset finished");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, calibrate, then every scenario in turn.
   initial begin
      repeat (16) @(negedge i_clock);
      chk(o_ctl_reg === sdbg_pkg::CTL_RESET && o_gpio_mode === 1'b1 && o_dbg_oe === 1'b0
          && o_runtime === 16'h0000, "reset values");
      i_rst_n = 1'b1;
      cal();
      t_rx();
      t_tx();
      t_brk();
      t_frame();
      t_coll();
      t_run();
      t_sys();
      test_done();
   end
endmodule
